//--- hw/parallel_port_control_bits.sv
/*
 Control lines, polarity, handshake mode store and single-bit data access
 for twelve 8-bit ports that may be grouped to 16, 32, 64 or 96 bits.
 Assumes request strobes come from logic on sys_clk; flag lines come from
 pins and are synchronised here.
*/
// Summary of operation
// (RULE_01) Twelve 8-bit ports 0..11, control line always selected by byte port number.
// (RULE_02) Each control line has polarity: positive true is high, negative true is low.
// (RULE_03) Reset makes every control line polarity positive.
// (RULE_04) Software sets or clears a port's logical control value; pin follows polarity.
// (RULE_05) Reset clears every control line to logical 0.
// (RULE_06) Control read returns the programmed logical bit, not the pin level.
// (RULE_07) Polarity of each control line can be read back.
// (RULE_08) Direct control writes and reads act only while the port's mode is none.
// (RULE_09) Control line and peripheral flag line form the two-way data handshake.
// (RULE_10) Single-bit writes on byte ports (0..7) and 16-bit groups (0..15).
// (RULE_11) Single-bit writes on 32, 64, 96-bit groups, indices 0..31, 0..63, 0..95.
// (RULE_12) 16-bit group joins two byte ports, base must be even 0..10.
// (RULE_13) 32-bit group joins four byte ports, base must be 0, 4 or 8.
// (RULE_14) 64-bit and 96-bit groups always start at byte port 0.
// (RULE_15) Six handshake modes per grouping, selectable and readable.
// (RULE_16) Pin level is stored value inverted for negative polarity, instantly.
// (RULE_17) Peripheral drives flag ready/busy; flag state readable one bit per port.
// (RULE_18) Illegal base or out-of-range bit index is rejected with no state change.
`timescale 1ns/1ps
module parallel_port_control_bits
    import par_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ctl_wr,
    input wire logic [3:0] ctl_sel,
    input wire logic ctl_value,
    input wire logic pol_wr,
    input wire logic [3:0] pol_sel,
    input wire logic pol_active_low,
    input wire logic mode_wr,
    input wire logic [2:0] mode_width,
    input wire logic [3:0] mode_port,
    input wire logic [2:0] mode_value,
    input wire logic bit_wr,
    input wire logic [2:0] bit_width,
    input wire logic [3:0] bit_port,
    input wire logic [6:0] bit_index,
    input wire logic bit_value,
    input wire logic [3:0] rd_sel,
    input wire logic [11:0] peripheral_flag_line,
    output logic [11:0] handshake_control_line,
    output logic [95:0] data_out,
    output logic ctl_rd_value,
    output logic pol_rd_active_low,
    output logic [2:0] mode_rd_value,
    output logic bit_rd_value,
    output logic [11:0] flag_state,
    output logic req_reject
);

    typedef struct packed {
        logic [11:0] ctl;
        logic [11:0] pol_neg;
        logic [11:0][2:0] mode;
        logic [95:0] data;
        logic [11:0] flag_meta;
        logic [11:0] flag_sync;
        logic ctl_rd;
        logic pol_rd;
        logic [2:0] mode_rd;
        logic bit_rd;
        logic reject;
    } state_t;

    localparam state_t STATE_RST = '{
        ctl: CTL_RST,
        pol_neg: POL_RST,
        mode: MODE_RST,
        data: DATA_RST,
        default: '0
    };

    state_t s_r;
    state_t s_nxt;

    function automatic logic [6:0] group_bits(input logic [2:0] w);
        case (w)
            GRP_BYTE: group_bits = BITS_BYTE;
            GRP_WORD: group_bits = BITS_WORD;
            GRP_32: group_bits = BITS_32;
            GRP_64: group_bits = BITS_64;
            GRP_96: group_bits = BITS_96;
            default: group_bits = 7'h00;
        endcase
    endfunction

    // Base port legality per grouping width
    function automatic logic base_ok(input logic [2:0] w, input logic [3:0] p);
        case (w)
            GRP_BYTE: base_ok = (p <= LAST_PORT);
            GRP_WORD: base_ok = (p <= WORD_LAST_BASE) && !p[0];
            GRP_32: base_ok = (p <= GROUP32_LAST_BASE) && (p[1:0] == 2'h0);
            GRP_64: base_ok = (p == GROUP_FIXED_BASE);
            GRP_96: base_ok = (p == GROUP_FIXED_BASE);
            default: base_ok = 1'b0;
        endcase
    endfunction

    function automatic logic bit_ok(input logic [2:0] w, input logic [3:0] p, input logic [6:0] i);
        bit_ok = base_ok(w, p) && (i < group_bits(w));
    endfunction

    // Bit index relative to a group base becomes an absolute data bit
    function automatic logic [6:0] abs_index(input logic [3:0] p, input logic [6:0] i);
        abs_index = 7'({p, 3'h0} + i);
    endfunction

    logic ctl_sel_ok;
    logic pol_sel_ok;
    logic rd_sel_ok;
    logic mode_ok;
    logic bit_req_ok;
    logic [6:0] bit_abs;
    logic [4:0] mode_span_end;
    logic [6:0] mode_bits;

    assign ctl_sel_ok = (ctl_sel <= LAST_PORT);
    assign pol_sel_ok = (pol_sel <= LAST_PORT);
    assign rd_sel_ok = (rd_sel <= LAST_PORT);
    assign mode_ok = base_ok(mode_width, mode_port) && (mode_value <= HS_LAST);
    assign bit_req_ok = bit_ok(bit_width, bit_port, bit_index);
    assign bit_abs = abs_index(bit_port, bit_index);
    assign mode_bits = group_bits(mode_width);
    assign mode_span_end = {1'b0, mode_port} + {1'b0, mode_bits[6:3]};

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.reject = 1'b0;
        // (RULE_01) control access by byte port number
        // (RULE_04) logical value stored
        // (RULE_08) blocked unless mode none
        if (ctl_wr)
        begin
            if (ctl_sel_ok && (s_r.mode[ctl_sel] == HS_NONE))
            begin
                s_nxt.ctl[ctl_sel] = ctl_value;
            end
            else
            begin
                s_nxt.reject = 1'b1;
            end
        end
        // (RULE_02) polarity per port
        if (pol_wr)
        begin
            if (pol_sel_ok)
            begin
                s_nxt.pol_neg[pol_sel] = pol_active_low;
            end
            else
            begin
                s_nxt.reject = 1'b1;
            end
        end
        // (RULE_15) mode written to every member port
        // (RULE_12) (RULE_13) (RULE_14) base checked
        if (mode_wr)
        begin
            if (mode_ok)
            begin
                for (int i = 0; i < NUM_PORTS; i++)
                begin
                    if ((5'(i) >= {1'b0, mode_port}) && (5'(i) < mode_span_end))
                    begin
                        s_nxt.mode[i] = mode_value;
                    end
                end
            end
            else
            begin
                s_nxt.reject = 1'b1;
            end
        end
        // (RULE_10) (RULE_11) single data bit write
        // (RULE_18) illegal request leaves state alone
        if (bit_wr)
        begin
            if (bit_req_ok)
            begin
                s_nxt.data[bit_abs] = bit_value;
            end
            else
            begin
                s_nxt.reject = 1'b1;
            end
        end
        // (RULE_06) (RULE_08) logical value, only while mode none
        s_nxt.ctl_rd = rd_sel_ok && (s_r.mode[rd_sel] == HS_NONE) && s_r.ctl[rd_sel];
        // (RULE_07) polarity readback
        s_nxt.pol_rd = rd_sel_ok && s_r.pol_neg[rd_sel];
        s_nxt.mode_rd = rd_sel_ok ? s_r.mode[rd_sel] : HS_NONE;
        s_nxt.bit_rd = bit_req_ok && s_r.data[bit_abs];
        // (RULE_17) (RULE_09) flag pins pass two flops before use
        s_nxt.flag_meta = peripheral_flag_line;
        s_nxt.flag_sync = s_r.flag_meta;
    end

    // (RULE_03) (RULE_05) reset to positive polarity, logical 0
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            s_r <= STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // (RULE_16) XOR keeps a polarity change visible on the pin at once
    assign handshake_control_line = s_r.ctl ^ s_r.pol_neg;
    assign data_out = s_r.data;
    assign ctl_rd_value = s_r.ctl_rd;
    assign pol_rd_active_low = s_r.pol_rd;
    assign mode_rd_value = s_r.mode_rd;
    assign bit_rd_value = s_r.bit_rd;
    assign flag_state = s_r.flag_sync;
    assign req_reject = s_r.reject;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic ctl_wr_good;
    logic pol_wr_good;
    assign ctl_wr_good = ctl_wr && ctl_sel_ok && (s_r.mode[ctl_sel] == HS_NONE);
    assign pol_wr_good = pol_wr && pol_sel_ok;

    sequence s_ctl_blocked;
        ctl_wr && ctl_sel_ok && (s_r.mode[ctl_sel] != HS_NONE);
    endsequence

    sequence s_bit_bad;
        bit_wr && !bit_req_ok;
    endsequence

    sequence s_wide_bad_base;
        mode_wr && (mode_width >= GRP_64) && (mode_width <= GRP_96) && (mode_port != GROUP_FIXED_BASE);
    endsequence

    sequence s_word_odd_base;
        mode_wr && (mode_width == GRP_WORD) && mode_port[0];
    endsequence

    sequence s_group32_bad_base;
        mode_wr && (mode_width == GRP_32) && (mode_port[1:0] != 2'h0);
    endsequence

    chk_reset_values: assert property (@(posedge sys_clk) disable iff (1'b0) // RULE_03 RULE_05
        !resetn |=> (s_r.ctl == CTL_RST) && (s_r.pol_neg == POL_RST) && (handshake_control_line == 12'h000))
        else $error("control or polarity not cleared by reset");

    chk_ctl_write_takes: assert property (ctl_wr_good |=> // RULE_04
        s_r.ctl[$past(ctl_sel)] == $past(ctl_value))
        else $error("control value write lost");

    chk_ctl_mode_block: assert property (s_ctl_blocked |=> $stable(s_r.ctl) && req_reject) // RULE_08
        else $error("control write accepted outside mode none");

    chk_pol_pin_level: assert property (pol_wr_good && !ctl_wr |=> // RULE_16
        handshake_control_line[$past(pol_sel)] == ($past(pol_active_low) ^ s_r.ctl[$past(pol_sel)]))
        else $error("pin level does not follow polarity");

    chk_pol_readback: assert property (pol_wr_good ##1 (rd_sel == $past(pol_sel)) |=> // RULE_07
        pol_rd_active_low == $past(pol_active_low, 2))
        else $error("polarity readback mismatch");

    chk_bit_write_takes: assert property (bit_wr && bit_req_ok |=> // RULE_11
        data_out[$past(bit_abs)] == $past(bit_value))
        else $error("single bit write lost");

    chk_bit_bad_reject: assert property (s_bit_bad |=> $stable(data_out) && req_reject) // RULE_18
        else $error("illegal bit request changed data");

    chk_word_even_base: assert property (s_word_odd_base |=> $stable(s_r.mode) && req_reject) // RULE_12
        else $error("odd 16-bit base accepted");

    chk_wide_fixed_base: assert property (s_wide_bad_base |=> $stable(s_r.mode) && req_reject) // RULE_14
        else $error("wide group accepted nonzero base");

    chk_group32_base: assert property (s_group32_bad_base |=> $stable(s_r.mode) && req_reject) // RULE_13
        else $error("32-bit group accepted a base off 0, 4 or 8");

    chk_ctl_read_mode: assert property (rd_sel_ok && (s_r.mode[rd_sel] != HS_NONE) |=> !ctl_rd_value) // RULE_08
        else $error("control readback shown outside mode none");

    chk_mode_store: assert property (mode_wr && mode_ok |=> // RULE_15
        s_r.mode[$past(mode_port)] == $past(mode_value))
        else $error("handshake mode not stored");

    chk_flag_sync_delay: assert property (##2 1'b1 |-> flag_state == $past(peripheral_flag_line, 2)) // RULE_17
        else $error("flag state not two cycles behind pins");

endmodule

//--- hw/par_pkg.sv
/*
 Constants and types for the twelve-port parallel control block.
 Assumes a single clock domain and a synchronous active-low reset.
*/
package par_pkg;
    localparam int NUM_PORTS = 12;
    localparam int DATA_W = 96;
    localparam int SEL_W = 4;
    localparam int IDX_W = 7;

    localparam logic [3:0] LAST_PORT = 4'hb;
    localparam logic [3:0] WORD_LAST_BASE = 4'ha;
    localparam logic [3:0] GROUP32_LAST_BASE = 4'h8;
    localparam logic [3:0] GROUP_FIXED_BASE = 4'h0;

    localparam logic [6:0] BITS_BYTE = 7'h08;
    localparam logic [6:0] BITS_WORD = 7'h10;
    localparam logic [6:0] BITS_32 = 7'h20;
    localparam logic [6:0] BITS_64 = 7'h40;
    localparam logic [6:0] BITS_96 = 7'h60;

    localparam logic [11:0] CTL_RST = 12'h000;
    localparam logic [11:0] POL_RST = 12'h000;
    localparam logic [35:0] MODE_RST = 36'h000000000;
    localparam logic [95:0] DATA_RST = 96'h0;

    typedef enum logic [2:0] {
        HS_NONE = 3'h0,
        HS_EDGE_A = 3'h1,
        HS_EDGE_B = 3'h2,
        HS_PULSED = 3'h3,
        HS_C = 3'h4,
        HS_STROBE = 3'h5
    } hs_mode_t;

    localparam logic [2:0] HS_LAST = 3'h5;

    typedef enum logic [2:0] {
        GRP_BYTE = 3'h0,
        GRP_WORD = 3'h1,
        GRP_32 = 3'h2,
        GRP_64 = 3'h3,
        GRP_96 = 3'h4
    } grp_width_t;
endpackage

//--- tb/flag_peripheral.sv
/*
 Peripheral model that answers every control line on its flag line.
 Assumes the block's sys_clk and resetn; slow widens the answer delay.
*/
`timescale 1ns/1ps
module flag_peripheral
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [11:0] handshake_control_line,
    output logic [11:0] peripheral_flag_line
);
    logic [11:0] d1_r, d2_r;
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            {d1_r, d2_r, peripheral_flag_line} <= '1;
        end
        else
        begin
            d1_r <= handshake_control_line;
            d2_r <= d1_r;
            peripheral_flag_line <= slow ? d2_r : d1_r;
        end
    end
endmodule

//--- tb/parallel_port_control_bits_test.sv
/*
 Self-checking bench: bench model of all port state, scoreboard queue.
 Assumes flag_peripheral on the flag pins; inputs change at falling edges.
*/
`timescale 1ns/1ps
module parallel_port_control_bits_test;
    import par_pkg::*;
    typedef struct {int what; logic [95:0] exp;} note_t;
    note_t notes[$];
    event look;
    int n_fail = 0;
    int tests_run = 0;
    logic sys_clk = 0, resetn = 0, slow = 0, ctl_wr = 0, ctl_value = 0, pol_wr = 0, pol_active_low = 0;
    logic mode_wr = 0, bit_wr = 0, bit_value = 0, ctl_rd_value, pol_rd_active_low, bit_rd_value, req_reject;
    logic [3:0] ctl_sel = 0, pol_sel = 0, mode_port = 0, bit_port = 0, rd_sel = 0;
    logic [2:0] mode_width = 0, mode_value = 0, bit_width = 0, mode_rd_value;
    logic [6:0] bit_index = 0;
    logic [11:0] peripheral_flag_line, handshake_control_line, flag_state, flag_seen, ctl_m = 0, pol_m = 0;
    logic [95:0] data_out, data_m = 0;
    logic [2:0] mode_m [12] = '{default: '0};

    parallel_port_control_bits i_dut (.sys_clk, .resetn, .ctl_wr, .ctl_sel, .ctl_value, .pol_wr, .pol_sel,
        .pol_active_low, .mode_wr, .mode_width, .mode_port, .mode_value, .bit_wr, .bit_width, .bit_port,
        .bit_index, .bit_value, .rd_sel, .peripheral_flag_line, .handshake_control_line, .data_out,
        .ctl_rd_value, .pol_rd_active_low, .mode_rd_value, .bit_rd_value, .flag_state, .req_reject);
    flag_peripheral i_peer (.sys_clk, .resetn, .slow, .handshake_control_line, .peripheral_flag_line);

    initial forever #20 sys_clk = ~sys_clk;

    function automatic logic base_ok(logic [2:0] w, logic [3:0] p);
        case (w)
            3'h0: return p <= LAST_PORT;
            3'h1: return !p[0] && p <= WORD_LAST_BASE;
            3'h2: return p[1:0] == 2'h0 && p <= GROUP32_LAST_BASE;
            3'h3, 3'h4: return p == GROUP_FIXED_BASE;
            default: return 1'h0;
        endcase
    endfunction

    function automatic logic [6:0] gbits(logic [2:0] w);
        return w == 3'h4 ? BITS_96 : 7'(BITS_BYTE << w);
    endfunction

    task automatic check(string nm, logic [95:0] seen, logic [95:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(look)
        while (notes.size() > 0)
        begin
            note_t n;
            n = notes.pop_front();
            case (n.what)
                0: check("data_out", data_out, n.exp);
                1: check("control pins", 96'(handshake_control_line), n.exp);
                2: check("ctl_rd_value", 96'(ctl_rd_value), n.exp);
                3: check("pol_rd_active_low", 96'(pol_rd_active_low), n.exp);
                4: check("mode_rd_value", 96'(mode_rd_value), n.exp);
                5: check("bit_rd_value", 96'(bit_rd_value), n.exp);
                6: check("req_reject", 96'(req_reject), n.exp);
                default: check("flag_state", 96'(flag_state), n.exp);
            endcase
        end

    // Inputs are set by the caller at a falling edge; one call is two cycles
    task automatic step();
        logic rej;
        int a;
        rej = 0;
        flag_seen = peripheral_flag_line;
        if (ctl_wr && ctl_sel <= LAST_PORT && mode_m[ctl_sel] == HS_NONE)
            ctl_m[ctl_sel] = ctl_value;
        else if (ctl_wr)
            rej = 1;
        if (pol_wr && pol_sel <= LAST_PORT)
            pol_m[pol_sel] = pol_active_low;
        else if (pol_wr)
            rej = 1;
        if (bit_wr && base_ok(bit_width, bit_port) && bit_index < gbits(bit_width))
            data_m[bit_port * 8 + bit_index] = bit_value;
        else if (bit_wr)
            rej = 1;
        if (mode_wr && base_ok(mode_width, mode_port) && mode_value <= HS_LAST)
            for (a = 0; a < gbits(mode_width) / 8; a++)
                mode_m[mode_port + a] = mode_value;
        else if (mode_wr)
            rej = 1;
        @(negedge sys_clk);
        {ctl_wr, pol_wr, mode_wr, bit_wr} = '0;
        notes.push_back('{6, 96'(rej)});
        -> look;
        @(negedge sys_clk);
        a = base_ok(bit_width, bit_port) && bit_index < gbits(bit_width) ? bit_port * 8 + bit_index : -1;
        notes.push_back('{0, data_m});
        notes.push_back('{1, 96'(ctl_m ^ pol_m)});
        notes.push_back('{2, 96'(rd_sel <= LAST_PORT && mode_m[rd_sel] == HS_NONE && ctl_m[rd_sel])});
        notes.push_back('{3, 96'(rd_sel <= LAST_PORT ? pol_m[rd_sel] : 1'h0)});
        notes.push_back('{4, 96'(rd_sel <= LAST_PORT ? mode_m[rd_sel] : 3'h0)});
        notes.push_back('{5, 96'(a >= 0 ? data_m[a] : 1'h0)});
        notes.push_back('{7, 96'(flag_seen)});
        -> look;
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'ha16c774c));
        for (int r = 0; r < 2; r++)
        begin
            repeat (20) @(negedge sys_clk);
            resetn = 1;
            {ctl_m, pol_m, data_m} = '0;
            mode_m = '{default: '0};
            for (int k = 0; k < 16; k++)
            begin
                rd_sel = 4'(k);
                step();
            end
            // Every mode code, then a direct write
            for (int m = 0; m < 8; m++)
            begin
                {mode_wr, mode_width, mode_port, mode_value, rd_sel} = {1'h1, 3'h0, 4'h3, 3'(m), 4'h3};
                step();
                {ctl_wr, ctl_sel, ctl_value} = {1'h1, 4'h3, 1'h1};
                step();
            end
            // Last index and one past it, every width
            for (int w = 0; w < 8; w++)
                for (int e = 0; e < 2; e++)
                begin
                    {bit_wr, bit_width, bit_port, bit_value} = {1'h1, 3'(w), 4'h0, 1'h1};
                    bit_index = gbits(3'(w)) - 7'h01 + 7'(e);
                    step();
                end
            repeat (300)
            begin
                {ctl_wr, pol_wr, bit_wr, ctl_value, pol_active_low, bit_value, slow} = 7'($urandom);
                {ctl_sel, pol_sel, rd_sel, mode_width, bit_width} = 18'($urandom);
                mode_wr = $urandom % 6 == 0;
                mode_value = $urandom % 2 ? 3'h0 : 3'($urandom);
                mode_port = $urandom % 2 ? 4'h0 : 4'($urandom);
                bit_port = $urandom % 2 ? 4'h0 : 4'($urandom);
                bit_index = 7'($urandom % 100);
                step();
            end
            resetn = 0;
        end
        // Let the scoreboard drain the last notes first
        @(negedge sys_clk);
        wrap_up();
    end
endmodule
